// ### shared/bpio_pkg.sv
// constants and types for the byte-grouped parallel io block
// Summary of operation
// - lines grouped in bytes, direction per byte
// - input bytes stay undriven
// - output polarity per byte, power-on level per line
// - tristate until self test, then load config
// - settled output only after configuration applied
// - bit set, clear, pulse or query
// - bit set, clear or pulse, or byte write, makes byte output unless locked
// - byte write and read, manual strobe
// - latch word first, then one strobe
// - bytes joined into one wide word
// - word capture direct or with handshake
// - per-bit inversion on byte read
// - per-bit inversion on byte write
// - monitor fifteen lines of lowest bytes
// - rise/fall select latches event bits
// - enabled event sets summary bit
// - two status inputs recorded and monitored
// - control signal polarity set separately
// - save config to nonvolatile, reload at power-on
// - lock freezes configuration
// - factory restore loads defaults
package bpio_pkg;
	localparam int NLINE = 128;
	localparam int NMON = 15;
	localparam logic [4:0] A_CTRL = 5'h00;
	localparam logic [4:0] A_BIT = 5'h01;
	localparam logic [4:0] A_BYTE = 5'h02;
	localparam logic [4:0] A_CFG0 = 5'h03;
	localparam logic [4:0] A_CFG5 = 5'h08;
	localparam logic [4:0] A_WORD0 = 5'h09;
	localparam logic [4:0] A_WORD3 = 5'h0C;
	localparam logic [4:0] A_EVENT = 5'h0D;
	localparam logic [4:0] A_EDGE = 5'h0E;
	localparam logic [4:0] A_EVEN = 5'h0F;
	localparam logic [4:0] A_OPST = 5'h10;
	localparam logic [2:0] CFG_LAST = 3'h5;
	localparam int CLK_NS = 50;
	localparam int STRB_NS = 1000;
	localparam logic [7:0] STRB_CYC = 8'(STRB_NS / CLK_NS);
	localparam logic [31:0] CTL_RST = {16'h0000, STRB_CYC, 8'h00};
	localparam int C_SPOL = 0;
	localparam int C_RPOL = 1;
	localparam int C_APOL = 2;
	localparam int C_HSEN = 4;
	localparam int C_WID = 8;
	localparam int K_SAVE = 0;
	localparam int K_DEF = 1;
	localparam int K_LOCK = 2;
	localparam int K_UNLOCK = 3;
	localparam int K_STRB = 4;
	localparam int K_CAP = 5;
	localparam int K_GO = 6;
	localparam logic [1:0] OP_SET = 2'h0;
	localparam logic [1:0] OP_CLR = 2'h1;
	localparam logic [1:0] OP_PULSE = 2'h2;
	typedef enum logic [1:0] {
		S_WAIT = 2'b00,
		S_LOAD = 2'b01,
		S_RUN = 2'b10,
		S_SAVE = 2'b11
	} bpio_st_t;
endpackage

// ### rtl/bpio_top.sv
// byte-grouped parallel io block with register port and config store
`timescale 1ns/10ps
`default_nettype none
module bpio_top (
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire logic [4:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	input  wire logic [127:0] pio_i,
	output logic      [127:0] pio_o,
	output logic      [127:0] pio_oe_o,
	output logic             strobe_o,
	output logic             hs_req_o,
	input  wire logic        hs_ack_i,
	input  wire logic [1:0]  stat_i,
	input  wire logic        selftest_ok_i,
	output logic             stable_o,
	output logic             summary_o,
	output logic             nv_rd_o,
	output logic             nv_wr_o,
	output logic      [2:0]  nv_addr_o,
	output logic      [31:0] nv_wdata_o,
	input  wire logic [31:0] nv_rdata_i
);
	function automatic logic [127:0] f_exp(input logic [15:0] m);
		logic [127:0] r;
		r = '0;
		for (int i = 0; i < 16; i++) begin
			r[i*8 +: 8] = {8{m[i]}};
		end
		return r;
	endfunction

	function automatic logic [7:0] f_byte(input logic [127:0] v, input logic [3:0] b);
		return v[b*8 +: 8];
	endfunction

	logic [127:0]       pin_s1, pin_s2, pin_s3;
	logic [1:0]         st_s1, st_s2, st_s3;
	logic               ack_s1, ack_s2, ok_s1, ok_s2;
	bpio_pkg::bpio_st_t st;
	logic [2:0]         ld_idx, rd_idx;
	logic               rd_pend, drv_en, lock;
	logic [31:0]        cfg [0:5];
	logic [127:0]       out_lvl, stage, in_word;
	logic [7:0]         stb_cnt, pls_cnt, stb_w;
	logic               stb_go, hs_busy;
	logic [6:0]         pls_ln, bit_ln;
	logic [3:0]         byte_sel;
	logic [7:0]         byte_mask;
	logic [14:0]        ev, ev_en, e_rise, e_fall, ev_set;
	logic [1:0]         op_chg;
	logic               run, busy, ld_done, ack_act;
	logic               wr_ctrl, wr_bit, wr_byte, wr_cfg, wr_word, ev_clr;
	logic [2:0]         cfg_idx;
	logic [1:0]         word_idx;

	assign run = (st == bpio_pkg::S_RUN);
	assign busy = stb_go || (stb_cnt != 8'h00) || (pls_cnt != 8'h00);
	assign ld_done = rd_pend && (rd_idx == bpio_pkg::CFG_LAST);
	assign wr_ctrl = wr_i && (addr_i == bpio_pkg::A_CTRL);
	assign wr_bit = wr_i && (addr_i == bpio_pkg::A_BIT);
	assign wr_byte = wr_i && (addr_i == bpio_pkg::A_BYTE);
	assign wr_cfg = wr_i && (addr_i >= bpio_pkg::A_CFG0) && (addr_i <= bpio_pkg::A_CFG5);
	assign wr_word = wr_i && (addr_i >= bpio_pkg::A_WORD0) && (addr_i <= bpio_pkg::A_WORD3);
	assign ev_clr = rd_i && (addr_i == bpio_pkg::A_EVENT);
	assign cfg_idx = 3'(addr_i - bpio_pkg::A_CFG0);
	assign word_idx = 2'(addr_i - bpio_pkg::A_WORD0);
	assign stb_w = (cfg[1][bpio_pkg::C_WID +: 8] == 8'h00) ? 8'h01 : cfg[1][bpio_pkg::C_WID +: 8];
	assign ack_act = ack_s2 ^ cfg[1][bpio_pkg::C_APOL];

	// pins pass two flops before use, reset to the pulled-up idle level
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_s1 <= '1;
			pin_s2 <= '1;
			pin_s3 <= '1;
			st_s1 <= 2'h0;
			st_s2 <= 2'h0;
			st_s3 <= 2'h0;
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
			ok_s1 <= 1'b0;
			ok_s2 <= 1'b0;
		end else begin
			pin_s1 <= pio_i;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			st_s1 <= stat_i;
			st_s2 <= st_s1;
			st_s3 <= st_s2;
			ack_s1 <= hs_ack_i;
			ack_s2 <= ack_s1;
			ok_s1 <= selftest_ok_i;
			ok_s2 <= ok_s1;
		end
	end

	// power-on sequence and config save
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= bpio_pkg::S_WAIT;
			ld_idx <= 3'h0;
			drv_en <= 1'b0;
		end else begin
			case (st)
				bpio_pkg::S_WAIT: begin
					ld_idx <= 3'h0;
					if (ok_s2) begin
						st <= bpio_pkg::S_LOAD;
					end
				end
				bpio_pkg::S_LOAD: begin
					if (ld_idx != bpio_pkg::CFG_LAST + 3'h1) begin
						ld_idx <= ld_idx + 3'h1;
					end
					if (ld_done) begin
						st <= bpio_pkg::S_RUN;
						drv_en <= 1'b1;
					end
				end
				bpio_pkg::S_RUN: begin
					ld_idx <= 3'h0;
					if (wr_ctrl && wdata_i[bpio_pkg::K_SAVE]) begin
						st <= bpio_pkg::S_SAVE;
					end
				end
				default: begin
					ld_idx <= ld_idx + 3'h1;
					if (ld_idx == bpio_pkg::CFG_LAST) begin
						st <= bpio_pkg::S_RUN;
					end
				end
			endcase
		end
	end

	assign nv_rd_o = (st == bpio_pkg::S_LOAD) && (ld_idx <= bpio_pkg::CFG_LAST);
	assign nv_wr_o = (st == bpio_pkg::S_SAVE);
	assign nv_addr_o = ld_idx;
	assign nv_wdata_o = (ld_idx <= bpio_pkg::CFG_LAST) ? cfg[ld_idx] : 32'h0000_0000;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_pend <= 1'b0;
			rd_idx <= 3'h0;
		end else begin
			rd_pend <= nv_rd_o;
			rd_idx <= ld_idx;
		end
	end

	// lock flag
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lock <= 1'b0;
		end else if (wr_ctrl && wdata_i[bpio_pkg::K_UNLOCK]) begin
			lock <= 1'b0;
		end else if (wr_ctrl && wdata_i[bpio_pkg::K_LOCK]) begin
			lock <= 1'b1;
		end
	end

	// config store: 0 dir/out polarity, 1 control, 2..5 power-on levels
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 6; i++) begin
				cfg[i] <= (i == 1) ? bpio_pkg::CTL_RST : '0;
			end
		end else if (rd_pend) begin
			cfg[rd_idx] <= nv_rdata_i;
		end else if (run && !lock) begin
			if (wr_ctrl && wdata_i[bpio_pkg::K_DEF]) begin
				for (int i = 0; i < 6; i++) begin
					cfg[i] <= (i == 1) ? bpio_pkg::CTL_RST : '0;
				end
			end else if (wr_cfg) begin
				cfg[cfg_idx] <= wdata_i;
			end else if (wr_bit && !busy && wdata_i[9:8] != 2'h3) begin
				cfg[0][wdata_i[6:3]] <= 1'b1;
			end else if (wr_byte && !busy && wdata_i[24]) begin
				cfg[0][wdata_i[3:0]] <= 1'b1;
			end
		end
	end

	// output latch, bit and byte commands, word latch
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_lvl <= '0;
		end else if (ld_done) begin
			out_lvl <= {nv_rdata_i, cfg[4], cfg[3], cfg[2]};
		end else if (pls_cnt == 8'h01) begin
			out_lvl[pls_ln] <= ~out_lvl[pls_ln];
		end else if (run && !busy) begin
			if (wr_bit && wdata_i[9:8] == bpio_pkg::OP_SET) begin
				out_lvl[wdata_i[6:0]] <= 1'b1;
			end else if (wr_bit && wdata_i[9:8] == bpio_pkg::OP_CLR) begin
				out_lvl[wdata_i[6:0]] <= 1'b0;
			end else if (wr_bit && wdata_i[9:8] == bpio_pkg::OP_PULSE) begin
				out_lvl[wdata_i[6:0]] <= ~out_lvl[wdata_i[6:0]];
			end else if (wr_byte && wdata_i[24]) begin
				out_lvl[wdata_i[3:0]*8 +: 8] <= wdata_i[15:8] ^ wdata_i[23:16];
			end else if (wr_ctrl && wdata_i[bpio_pkg::K_GO]) begin
				out_lvl <= (out_lvl & ~f_exp(cfg[0][15:0])) | (stage & f_exp(cfg[0][15:0]));
			end
		end
	end

	assign pio_o = out_lvl ^ f_exp(cfg[0][31:16]);
	assign pio_oe_o = drv_en ? f_exp(cfg[0][15:0]) : '0;
	assign stable_o = drv_en;

	// word staging and command selections
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stage <= '0;
			bit_ln <= 7'h00;
			byte_sel <= 4'h0;
			byte_mask <= 8'h00;
		end else begin
			if (wr_word) begin
				stage[word_idx*32 +: 32] <= wdata_i;
			end
			if (wr_bit) begin
				bit_ln <= wdata_i[6:0];
			end
			if (wr_byte) begin
				byte_sel <= wdata_i[3:0];
				byte_mask <= wdata_i[23:16];
			end
		end
	end

	// strobe and bit pulse timing
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stb_go <= 1'b0;
			stb_cnt <= 8'h00;
			pls_cnt <= 8'h00;
			pls_ln <= 7'h00;
		end else begin
			stb_go <= run && !busy && wr_ctrl && (wdata_i[bpio_pkg::K_GO] || wdata_i[bpio_pkg::K_STRB]);
			if (stb_go) begin
				stb_cnt <= stb_w;
			end else if (stb_cnt != 8'h00) begin
				stb_cnt <= stb_cnt - 8'h01;
			end
			if (run && !busy && wr_bit && wdata_i[9:8] == bpio_pkg::OP_PULSE) begin
				pls_cnt <= stb_w;
				pls_ln <= wdata_i[6:0];
			end else if (pls_cnt != 8'h00) begin
				pls_cnt <= pls_cnt - 8'h01;
			end
		end
	end

	assign strobe_o = (stb_cnt != 8'h00) ^ cfg[1][bpio_pkg::C_SPOL];
	assign hs_req_o = hs_busy ^ cfg[1][bpio_pkg::C_RPOL];

	// input word capture
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hs_busy <= 1'b0;
			in_word <= '0;
		end else if (hs_busy) begin
			if (ack_act) begin
				hs_busy <= 1'b0;
				in_word <= (pin_s2 ^ f_exp(cfg[0][31:16])) & ~f_exp(cfg[0][15:0]);
			end
		end else if (run && wr_ctrl && wdata_i[bpio_pkg::K_CAP]) begin
			if (cfg[1][bpio_pkg::C_HSEN]) begin
				hs_busy <= 1'b1;
			end else begin
				in_word <= (pin_s2 ^ f_exp(cfg[0][31:16])) & ~f_exp(cfg[0][15:0]);
			end
		end
	end

	assign ev_set = (pin_s2[14:0] & ~pin_s3[14:0] & e_rise) | (~pin_s2[14:0] & pin_s3[14:0] & e_fall);

	// event monitoring, set wins over read clear
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ev <= 15'h0000;
			ev_en <= 15'h0000;
			e_rise <= 15'h0000;
			e_fall <= 15'h0000;
			op_chg <= 2'h0;
		end else begin
			ev <= (ev & ~{15{ev_clr}}) | ev_set;
			if (wr_i && addr_i == bpio_pkg::A_EDGE) begin
				e_rise <= wdata_i[14:0];
				e_fall <= wdata_i[30:16];
			end
			if (wr_i && addr_i == bpio_pkg::A_EVEN) begin
				ev_en <= wdata_i[14:0];
			end
			op_chg <= (op_chg & ~{2{rd_i && addr_i == bpio_pkg::A_OPST}}) | (st_s2 ^ st_s3);
		end
	end

	assign summary_o = |(ev & ev_en);

	// register read port
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (!rd_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (addr_i == bpio_pkg::A_CTRL) begin
			rdata_o <= {25'h0, st, summary_o, hs_busy, busy, lock, drv_en};
		end else if (addr_i == bpio_pkg::A_BIT) begin
			rdata_o <= {31'h0, pin_s2[bit_ln]};
		end else if (addr_i == bpio_pkg::A_BYTE) begin
			rdata_o <= {24'h0, f_byte(pin_s2, byte_sel) ^ byte_mask};
		end else if (addr_i >= bpio_pkg::A_CFG0 && addr_i <= bpio_pkg::A_CFG5) begin
			rdata_o <= cfg[cfg_idx];
		end else if (addr_i >= bpio_pkg::A_WORD0 && addr_i <= bpio_pkg::A_WORD3) begin
			rdata_o <= in_word[word_idx*32 +: 32];
		end else if (addr_i == bpio_pkg::A_EVENT) begin
			rdata_o <= {17'h0, ev};
		end else if (addr_i == bpio_pkg::A_EDGE) begin
			rdata_o <= {1'b0, e_fall, 1'b0, e_rise};
		end else if (addr_i == bpio_pkg::A_EVEN) begin
			rdata_o <= {17'h0, ev_en};
		end else if (addr_i == bpio_pkg::A_OPST) begin
			rdata_o <= {28'h0, op_chg, st_s2};
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end

	tri_wait_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(st == bpio_pkg::S_WAIT || st == bpio_pkg::S_LOAD) |-> pio_oe_o == '0 && !stable_o)
		else $error("lines driven before config load");
	input_hiz_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(pio_oe_o & ~f_exp(cfg[0][15:0])) == '0) else $error("input byte driven");
	stable_late_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(stable_o) |-> $past(rd_pend) && $past(rd_idx) == bpio_pkg::CFG_LAST)
		else $error("settled raised before last config word");
	strobe_after_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(stb_cnt != 8'h00) |-> $past(stb_go) && $stable(pio_o))
		else $error("strobe not after latch");
	strobe_data_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(stb_cnt != 8'h00) && $past(stb_cnt != 8'h00) |-> $stable(pio_o))
		else $error("data moved during strobe");
	event_latch_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		ev_set != 15'h0000 |=> (ev & $past(ev_set)) == $past(ev_set))
		else $error("edge did not latch event");
	event_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		ev_clr && ev_set == 15'h0000 |=> ev == 15'h0000 && !summary_o)
		else $error("event read did not clear");
	lock_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		lock && run && !rd_pend |=> cfg[0] == $past(cfg[0]) && cfg[1] == $past(cfg[1]))
		else $error("config changed while locked");
	auto_dir_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		run && !lock && !busy && wr_byte && wdata_i[24] |=> cfg[0][$past(wdata_i[3:0])])
		else $error("byte write left byte as input");
	byte_inv_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		rd_i && addr_i == bpio_pkg::A_BYTE |=>
		rdata_o[7:0] == ($past(f_byte(pin_s2, byte_sel)) ^ $past(byte_mask)))
		else $error("byte read inversion wrong");
	stable_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		stable_o |=> stable_o) else $error("settled indication dropped");
	busy_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(stb_cnt > 8'h01) && (wr_bit || wr_byte) |=> $stable(pio_o))
		else $error("line command acted during strobe");
endmodule
`default_nettype wire

// ### bench/bpio_dev.sv
// model of the external devices, handshake partner and config memory
`timescale 1ns/10ps
`default_nettype none
module bpio_dev (
	input  wire logic         mclk_i,
	input  wire logic [127:0] drv_i,
	input  wire logic [127:0] pio_o_i,
	input  wire logic [127:0] pio_oe_i,
	output logic      [127:0] pio_lvl_o,
	input  wire logic         hs_req_i,
	output logic              hs_ack_o,
	input  wire logic         nv_rd_i,
	input  wire logic         nv_wr_i,
	input  wire logic [2:0]   nv_addr_i,
	input  wire logic [31:0]  nv_wdata_i,
	output logic      [31:0]  nv_rdata_o
);
	logic [31:0] mem [0:5];
	logic        rd_q = 1'b0;
	logic [2:0]  a_q = 3'h0;
	logic [2:0]  ack_cnt = 3'h0;
	// a wire shows the block's level where it drives, else the external level
	assign pio_lvl_o = (pio_oe_i & pio_o_i) | (~pio_oe_i & drv_i);
	// read data stands one cycle only, otherwise an inverted pattern
	assign nv_rdata_o = rd_q ? mem[a_q] : ~mem[a_q];
	always @(posedge mclk_i) begin
		rd_q <= nv_rd_i;
		a_q <= nv_addr_i;
		if (nv_wr_i) begin
			mem[nv_addr_i] <= nv_wdata_i;
		end
	end
	// acknowledge a request four cycles late, drop it with the request
	always_ff @(posedge mclk_i) begin
		ack_cnt <= hs_req_i ? ((ack_cnt == 3'h3) ? ack_cnt : ack_cnt + 3'h1) : 3'h0;
		hs_ack_o <= hs_req_i && (ack_cnt == 3'h3);
	end
endmodule
`default_nettype wire

// ### bench/tb_byte_grouped_parallel_io.sv
// self-checking testbench for the byte-grouped parallel io block
`timescale 1ns/10ps
`default_nettype none
module tb_byte_grouped_parallel_io;
	logic         mclk_i, rst_n_i, wr, rd, strobe, hs_req, hs_ack, selftest_ok;
	logic         stable, summary, nv_rd, nv_wr;
	logic [4:0]   addr;
	logic [31:0]  wdata, rdata, nv_wdata, nv_rdata, d;
	logic [127:0] pio_i, pio_o, pio_oe, drv;
	logic [1:0]   stat;
	logic [2:0]   nv_addr;
	int           failures = 0;
	int           n_tests = 0;
	int           n;
	bpio_top DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pio_i(pio_i), .pio_o(pio_o),
		.pio_oe_o(pio_oe), .strobe_o(strobe), .hs_req_o(hs_req), .hs_ack_i(hs_ack),
		.stat_i(stat), .selftest_ok_i(selftest_ok), .stable_o(stable),
		.summary_o(summary), .nv_rd_o(nv_rd), .nv_wr_o(nv_wr), .nv_addr_o(nv_addr),
		.nv_wdata_o(nv_wdata), .nv_rdata_i(nv_rdata));
	bpio_dev DEV (.mclk_i(mclk_i), .drv_i(drv), .pio_o_i(pio_o), .pio_oe_i(pio_oe),
		.pio_lvl_o(pio_i), .hs_req_i(hs_req), .hs_ack_o(hs_ack), .nv_rd_i(nv_rd),
		.nv_wr_i(nv_wr), .nv_addr_i(nv_addr), .nv_wdata_i(nv_wdata),
		.nv_rdata_o(nv_rdata));
	initial begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end
	task automatic chk(input logic [127:0] s, input logic [127:0] e);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH at %0t: got %h expected %h", $time, s, e);
		end
	endtask
	task automatic wreg(input logic [4:0] a, input logic [31:0] v);
		@(posedge mclk_i);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk_i);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [4:0] a);
		@(posedge mclk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_i);
		rd <= 1'b0;
		@(negedge mclk_i);
		d = rdata;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge mclk_i);
	endtask
	task automatic t_power;
		cyc(6);
		chk(pio_oe, 128'h0);
		chk(stable, 1'b0);
		@(posedge mclk_i);
		selftest_ok <= 1'b1;
		n = 0;
		while (stable !== 1'b1 && n < 40) begin
			cyc(1);
			n++;
		end
		chk(stable, 1'b1);
		chk(pio_oe, {96'h0, 32'hFFFF_0000});
		chk(pio_o[31:16], 16'h5A5A);
		$display("power-on test done");
	endtask
	task automatic t_byte;
		drv[7:0] <= 8'h96;
		wreg(bpio_pkg::A_BYTE, 32'h010F_3C04);
		cyc(2);
		chk(pio_oe[39:32], 8'hFF);
		chk(pio_o[39:32], 8'h33);
		chk(pio_oe[7:0], 8'h00);
		wreg(bpio_pkg::A_BYTE, 32'h00F0_0000);
		cyc(3);
		rreg(bpio_pkg::A_BYTE);
		chk(d[7:0], 8'h66);
		drv[7:0] <= 8'h00;
		$display("byte test done");
	endtask
	task automatic t_bit;
		wreg(bpio_pkg::A_BIT, 32'h0000_0028);
		cyc(2);
		chk(pio_oe[47:40], 8'hFF);
		chk(pio_o[40], 1'b1);
		wreg(bpio_pkg::A_BIT, 32'h0000_0228);
		cyc(2);
		chk(pio_o[40], 1'b0);
		cyc(8);
		chk(pio_o[40], 1'b1);
		wreg(bpio_pkg::A_BIT, 32'h0000_0328);
		cyc(4);
		rreg(bpio_pkg::A_BIT);
		chk(d[0], 1'b1);
		wreg(bpio_pkg::A_BIT, 32'h0000_0128);
		cyc(2);
		chk(pio_o[40], 1'b0);
		$display("bit test done");
	endtask
	task automatic t_word;
		wreg(bpio_pkg::A_WORD0, 32'h1234_5678);
		wreg(bpio_pkg::A_CTRL, 32'h0000_0040);
		n = 0;
		while (strobe !== 1'b1 && n < 10) begin
			cyc(1);
			n++;
		end
		chk(pio_o[31:16], 16'hED34);
		n = 0;
		while (strobe === 1'b1 && n < 40) begin
			chk(pio_o[31:16], 16'hED34);
			cyc(1);
			n++;
		end
		chk(n, 4);
		$display("word test done");
	endtask
	task automatic t_event;
		wreg(bpio_pkg::A_EDGE, 32'h0002_0001);
		wreg(bpio_pkg::A_EVEN, 32'h0000_0003);
		drv[1:0] <= 2'b11;
		cyc(8);
		chk(summary, 1'b1);
		rreg(bpio_pkg::A_EVENT);
		chk(d, 32'h1);
		cyc(2);
		chk(summary, 1'b0);
		drv[1] <= 1'b0;
		cyc(8);
		rreg(bpio_pkg::A_EVENT);
		chk(d, 32'h2);
		$display("event test done");
	endtask
	task automatic t_misc;
		@(posedge mclk_i);
		stat <= 2'b10;
		drv[15:0] <= 16'hBEEC;
		wreg(5'h04, 32'h0000_0410);
		wreg(bpio_pkg::A_CTRL, 32'h0000_0020);
		cyc(4);
		chk(hs_req, 1'b1);
		n = 0;
		while (hs_req === 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		rreg(bpio_pkg::A_WORD0);
		chk(d[15:0], 16'hBEEC);
		rreg(bpio_pkg::A_OPST);
		chk(d[1:0], 2'b10);
		wreg(bpio_pkg::A_CTRL, 32'h0000_0004);
		wreg(5'h04, 32'h0000_0800);
		rreg(5'h04);
		chk(d, 32'h0000_0410);
		wreg(bpio_pkg::A_CTRL, 32'h0000_0008);
		wreg(bpio_pkg::A_CTRL, 32'h0000_0001);
		cyc(12);
		chk(DEV.mem[1], 32'h0000_0410);
		chk(DEV.mem[0], 32'h0008_003C);
		wreg(bpio_pkg::A_CTRL, 32'h0000_0002);
		rreg(5'h04);
		chk(d, bpio_pkg::CTL_RST);
		$display("config test done");
	endtask
	task automatic t_reload;
		@(posedge mclk_i);
		rst_n_i <= 1'b0;
		cyc(2);
		chk(pio_oe, 128'h0);
		chk(stable, 1'b0);
		@(posedge mclk_i);
		rst_n_i <= 1'b1;
		n = 0;
		while (stable !== 1'b1 && n < 40) begin
			cyc(1);
			n++;
		end
		chk(pio_oe, {80'h0, 32'hFFFF_FFFF, 16'h0});
		chk(pio_o[31:16], 16'h5A5A);
		wreg(5'h04, 32'h0000_0407);
		cyc(1);
		chk(strobe, 1'b1);
		chk(hs_req, 1'b1);
		wreg(bpio_pkg::A_CTRL, 32'h0000_0010);
		wreg(bpio_pkg::A_BIT, 32'h0000_0028);
		cyc(1);
		chk(strobe, 1'b0);
		chk(pio_o[40], 1'b0);
		$display("reload test done");
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		{rst_n_i, wr, rd, selftest_ok} = 4'h0;
		addr = 5'h00;
		wdata = 32'h0;
		drv = 128'h0;
		stat = 2'b00;
		DEV.mem[0] = 32'h0008_000C;
		DEV.mem[1] = 32'h0000_0400;
		DEV.mem[2] = 32'hA55A_0000;
		for (int i = 3; i < 6; i++) begin
			DEV.mem[i] = 32'h0;
		end
		repeat (2) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		t_power;
		t_byte;
		t_bit;
		t_word;
		t_event;
		t_misc;
		t_reload;
		report_and_stop;
	end
	initial begin
		repeat (4000) @(posedge mclk_i);
		failures++;
		report_and_stop;
	end
endmodule
`default_nettype wire
